// [verilog/pwr_seq_regs.svh]
// timing constants and encodings for the power-state sequencer
// assumes a 50 MHz always-on standby clock
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH

// ----------------------------------------
// clock and press timing
// ----------------------------------------
`define CLK_FREQ_HZ 50000000
`define SHORT_PRESS_MAX_S 4
`define LONG_PRESS_MIN_S 6
// cycle-count limits derived from seconds and clock rate
`define SHORT_PRESS_CYC (`SHORT_PRESS_MAX_S * `CLK_FREQ_HZ)
`define LONG_PRESS_CYC (`LONG_PRESS_MIN_S * `CLK_FREQ_HZ)

// ----------------------------------------
// wake source bit positions in the wake vector
// ----------------------------------------
`define WAKE_RTC 0
`define WAKE_LAN 1
`define WAKE_USB 2
`define WAKE_PME 3
`define WAKE_PCIE 4
`define WAKE_NUM 5

`endif

// [verilog/pwr_seq_pkg.sv]
// types shared by the power-state sequencer files
// assumes pwr_seq_regs.svh is on the include path
package pwr_seq_pkg;

	// ----------------------------------------
	// sleep state reported to the outside
	// ----------------------------------------
	typedef enum logic [2:0] {
		st_s0,
		st_s1,
		st_s3,
		st_s4,
		st_s5
	} sys_state_e;

	// ----------------------------------------
	// software command carrier
	// ----------------------------------------
	typedef struct packed {
		logic valid;     // one-cycle command strobe
		sys_state_e target; // requested state
	} os_cmd_s;

	// ----------------------------------------
	// press classifier output
	// ----------------------------------------
	typedef struct packed {
		logic short_rel; // released before four seconds
		logic long_hit;  // six seconds reached while held
	} press_evt_s;

endpackage : pwr_seq_pkg

// [verilog/press_timer.sv]
// classifies power-switch presses by duration
// assumes press input already synchronised to clk
`timescale 1ns/10ps
`include "pwr_seq_regs.svh"

module press_timer
	import pwr_seq_pkg::*;
#(
	parameter int unsigned SHORT_CYC = `SHORT_PRESS_CYC,
	parameter int unsigned LONG_CYC = `LONG_PRESS_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pressed,
	output press_evt_s evt
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] count; // cycles held so far
		logic held;         // press seen last cycle
		logic fired;        // long action already taken
		press_evt_s evt;    // registered events
	} timer_state_s;

	timer_state_s state_reg;
	timer_state_s state_next;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.evt = '0;
		state_next.held = pressed;
		if (pressed) begin
			// saturate so a stuck switch never wraps round to a short press
			if (state_reg.count != 32'hffffffff) begin
				state_next.count = state_reg.count + 32'h1;
			end
			if (!state_reg.fired && (state_reg.count + 32'h1) >= 32'(LONG_CYC)) begin
				state_next.evt.long_hit = 1'b1;
				state_next.fired = 1'b1;
			end
		end else begin
			// release: short only under the four-second limit
			if (state_reg.held && state_reg.count < 32'(SHORT_CYC)) begin
				state_next.evt.short_rel = 1'b1;
			end
			state_next.count = '0;
			state_next.fired = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign evt = state_reg.evt;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_short_bound: assert property (@(posedge clk) disable iff (sys_rst)
		evt.short_rel |-> $past(state_reg.count, 1) < 32'(SHORT_CYC))
		else $error("short press reported past limit");
	chk_long_once: assert property (@(posedge clk) disable iff (sys_rst)
		evt.long_hit |=> !evt.long_hit)
		else $error("long press reported twice");
	// a release past the short limit stays silent
	chk_mid_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		(!pressed && state_reg.held && state_reg.count >= 32'(SHORT_CYC)) |=> !evt.short_rel)
		else $error("release past short limit reported");
	// the long action comes on the held cycle that reaches the limit
	chk_long_timely: assert property (@(posedge clk) disable iff (sys_rst)
		(pressed && !state_reg.fired && state_reg.count == 32'(LONG_CYC - 1)) |=> evt.long_hit)
		else $error("long hold not reported on time");

endmodule : press_timer

// [verilog/power_button_wake_sequencer.sv]
// system power-state sequencer: switch presses, wake sources, os commands
// assumes an always-on standby clock; switch and wake pins are asynchronous
`timescale 1ns/10ps
`include "pwr_seq_regs.svh"

module power_button_wake_sequencer
	import pwr_seq_pkg::*;
#(
	parameter int unsigned SHORT_CYC = `SHORT_PRESS_CYC,
	parameter int unsigned LONG_CYC = `LONG_PRESS_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pwr_switch_n,
	input wire logic rtc_alarm,
	input wire logic lan_wake,
	input wire logic usb_wake,
	input wire logic pme_n,
	input wire logic pcie_wake_n,
	input os_cmd_s os_cmd,
	input wire logic [1:0] short_sleep_sel,
	output sys_state_e sys_state,
	output logic state_changed
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	// pin synchronisers ride in the same struct as the sequencer state
	typedef struct packed {
		logic [5:0] sync1; // first stage, read only by the second
		logic [5:0] sync2; // second stage, safe to use
		sys_state_e cur; // present system state
		logic changed; // pulse on each change
	} seq_state_s;

	seq_state_s state_reg; // registered state
	seq_state_s state_next; // next-state copy

	logic pressed; // switch closed
	logic [`WAKE_NUM-1:0] wake_req; // active-high wake vector
	// bit 5 is the switch; the low bits follow the wake vector positions
	assign pressed = state_reg.sync2[5];
	assign wake_req = state_reg.sync2[`WAKE_NUM-1:0];

	// ----------------------------------------
	// press classification
	// ----------------------------------------
	press_evt_s evt; // short release or long hold
	press_timer #(
		.SHORT_CYC(SHORT_CYC),
		.LONG_CYC(LONG_CYC)
	) u_press_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.pressed(pressed),
		.evt(evt)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// any sleeping or soft-off state
	function automatic logic is_asleep(input sys_state_e s);
		return (s != st_s0);
	endfunction : is_asleep

	// wake allowed for this state, usb only from S1/S3
	function automatic logic wake_ok(input sys_state_e s, input logic [`WAKE_NUM-1:0] w);
		logic usb_ok;
		logic others;
		usb_ok = w[`WAKE_USB] && (s == st_s1 || s == st_s3);
		others = w[`WAKE_RTC] | w[`WAKE_LAN] | w[`WAKE_PME] | w[`WAKE_PCIE];
		return is_asleep(s) && (usb_ok || others);
	endfunction : wake_ok

	// sleep state a short press enters from working
	function automatic sys_state_e sleep_target(input logic [1:0] sel);
		sys_state_e t;
		t = st_s1;
		if (sel == 2'h1) begin
			t = st_s3;
		end else if (sel == 2'h2) begin
			t = st_s4;
		end
		return t;
	endfunction : sleep_target

	// ----------------------------------------
	// transition logic
	// ----------------------------------------
	// priority: long hold, short press, wake, os command.
	// the forced off beats everything so a hung system can always be killed
	always_comb begin
		state_next = state_reg;
		state_next.changed = 1'b0;
		// two flops per pin; low-active pins are turned to active-high here
		state_next.sync1 = {~pwr_switch_n, ~pcie_wake_n, ~pme_n, usb_wake, lan_wake, rtc_alarm};
		state_next.sync2 = state_reg.sync1;
		if (evt.long_hit) begin
			// fail-safe off from working or sleep
			if (state_reg.cur != st_s5) begin
				state_next.cur = st_s5;
			end
		end else if (evt.short_rel) begin
			if (state_reg.cur == st_s0) begin
				state_next.cur = sleep_target(short_sleep_sel);
			end else begin
				state_next.cur = st_s0;
			end
		end else if (wake_ok(state_reg.cur, wake_req)) begin
			state_next.cur = st_s0;
		end else if (os_cmd.valid) begin
			// os owns ordinary transitions, including soft-off
			state_next.cur = os_cmd.target;
		end
		state_next.changed = (state_next.cur != state_reg.cur);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// one register bank for synchronisers and state alike
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// stages clear to the idle sense so no false press or wake follows reset
			state_reg <= '{sync1: 6'h00, sync2: 6'h00, cur: st_s5, changed: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// both outputs come straight from flops
	assign sys_state = state_reg.cur;
	assign state_changed = state_reg.changed;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// a long hold wins over every other request
	chk_long_off: assert property (@(posedge clk) disable iff (sys_rst)
		evt.long_hit |=> sys_state == st_s5)
		else $error("long hold did not force soft-off");

	// short press from any non-working state comes back to working
	chk_short_wake: assert property (@(posedge clk) disable iff (sys_rst)
		(evt.short_rel && !evt.long_hit && sys_state != st_s0) |=> sys_state == st_s0)
		else $error("short press did not wake");

	// short press from working always leaves working
	// a short release and a long hit never share a cycle: one needs the switch open
	chk_short_sleep: assert property (@(posedge clk) disable iff (sys_rst)
		(evt.short_rel && sys_state == st_s0) |=> sys_state != st_s0)
		else $error("short press did not sleep");

	// wake sources other than usb work from every sleeping state
	chk_wake_src: assert property (@(posedge clk) disable iff (sys_rst)
		(!evt.long_hit && !evt.short_rel && is_asleep(sys_state)
		&& (wake_req & 5'h1b) != 5'h0) |=> sys_state == st_s0)
		else $error("wake request ignored");

	// usb wakes the light sleep states
	chk_usb_light: assert property (@(posedge clk) disable iff (sys_rst)
		(evt == '0 && (sys_state == st_s1 || sys_state == st_s3)
		&& wake_req[`WAKE_USB]) |=> sys_state == st_s0)
		else $error("usb wake ignored in light sleep");

	// usb alone never lifts the deep states
	chk_usb_deep: assert property (@(posedge clk) disable iff (sys_rst)
		(evt == '0 && !os_cmd.valid && (sys_state == st_s4 || sys_state == st_s5)
		&& wake_req == 5'h04) |=> sys_state == $past(sys_state))
		else $error("usb woke from deep state");

	// software owns ordinary transitions when nothing outranks it
	chk_os_cmd: assert property (@(posedge clk) disable iff (sys_rst)
		(os_cmd.valid && evt == '0 && !wake_ok(sys_state, wake_req))
		|=> sys_state == $past(os_cmd.target))
		else $error("os command not obeyed");

	// software soft-off needs no switch
	chk_soft_off: assert property (@(posedge clk) disable iff (sys_rst)
		(os_cmd.valid && os_cmd.target == st_s5 && evt == '0 && !wake_ok(sys_state, wake_req))
		|=> sys_state == st_s5)
		else $error("soft-off command failed");

	// a wake in the same cycle outranks a software command, which is lost
	chk_wake_beats_os: assert property (@(posedge clk) disable iff (sys_rst)
		(evt == '0 && os_cmd.valid && wake_ok(sys_state, wake_req))
		|=> sys_state == st_s0)
		else $error("software command beat a wake");

	// quiet cycles hold the state
	chk_quiet_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(evt == '0 && !os_cmd.valid && !wake_ok(sys_state, wake_req)) |=> $stable(sys_state))
		else $error("state moved without cause");

	// change pulse marks exactly the cycles in which the state moved
	chk_changed_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst)
		|-> state_changed == (sys_state != $past(sys_state)))
		else $error("change pulse out of step");

	// ----------------------------------------
	// cover points
	// ----------------------------------------
	// the main paths through the sequencer
	cov_wake_s3: cover property (@(posedge clk) disable iff (sys_rst)
		sys_state == st_s3 ##1 sys_state == st_s0);
	cov_long: cover property (@(posedge clk) disable iff (sys_rst) evt.long_hit);
	cov_short: cover property (@(posedge clk) disable iff (sys_rst) evt.short_rel);
	cov_os_off: cover property (@(posedge clk) disable iff (sys_rst)
		os_cmd.valid && os_cmd.target == st_s5);
	cov_usb_wake: cover property (@(posedge clk) disable iff (sys_rst)
		sys_state == st_s3 && wake_req[`WAKE_USB] ##1 sys_state == st_s0);

endmodule : power_button_wake_sequencer

// [bench/far_side.sv]
// far-side model: front-panel switch and wake sources of the sequencer
// assumes the bench drives press and wake_req at the falling clock edge
`timescale 1ns/10ps
`include "pwr_seq_regs.svh"

module far_side (
	input wire logic press, // switch held by the user
	input wire logic [4:0] wake_req, // one bit per wake source
	output logic pwr_switch_n,
	output logic rtc_alarm,
	output logic lan_wake,
	output logic usb_wake,
	output logic pme_n,
	output logic pcie_wake_n
);
	// ----------------------------------------
	// pin levels
	// ----------------------------------------
	// idle levels are driven, never left floating, so no stale value lingers
	assign pwr_switch_n = ~press; // low while pressed
	assign rtc_alarm = wake_req[`WAKE_RTC];
	assign lan_wake = wake_req[`WAKE_LAN];
	assign usb_wake = wake_req[`WAKE_USB];
	assign pme_n = ~wake_req[`WAKE_PME]; // shared open-drain line, low active
	assign pcie_wake_n = ~wake_req[`WAKE_PCIE];
endmodule : far_side

// [bench/tb_top.sv]
// self-checking bench for the power-state sequencer
// assumes short counts of 40 and 60 cycles stand in for four and six seconds
`timescale 1ns/10ps
`include "pwr_seq_regs.svh"

module tb_top;
	import pwr_seq_pkg::*;
	localparam int SC = 40; // short-press limit in cycles
	localparam int LC = 60; // long-press limit in cycles
	logic clk, sys_rst, press, state_changed;
	logic pwr_switch_n, rtc_alarm, lan_wake, usb_wake, pme_n, pcie_wake_n;
	logic [4:0] wake_req; // requests to the far-side model
	logic [1:0] short_sleep_sel;
	os_cmd_s os_cmd;
	sys_state_e sys_state;
	int fails, n_tests, cyc;
	// one row: start state, sleep select, action, argument, expected state
	typedef struct {sys_state_e init; logic [1:0] sel; int act; int arg; sys_state_e exp;} row_s;
	row_s rows[17] = '{
		'{st_s5, 2'h1, 1, 10, st_s0}, '{st_s0, 2'h1, 1, 10, st_s3}, '{st_s0, 2'h0, 1, 10, st_s1},
		'{st_s0, 2'h2, 1, 10, st_s4}, '{st_s0, 2'h3, 1, 10, st_s1}, '{st_s3, 2'h1, 1, 10, st_s0},
		'{st_s4, 2'h1, 1, 10, st_s0}, '{st_s0, 2'h1, 1, 70, st_s5}, '{st_s1, 2'h1, 1, 70, st_s5},
		'{st_s5, 2'h1, 2, 0, st_s0}, '{st_s4, 2'h1, 2, 1, st_s0}, '{st_s5, 2'h1, 2, 2, st_s5},
		'{st_s3, 2'h1, 2, 2, st_s0}, '{st_s1, 2'h1, 2, 3, st_s0}, '{st_s5, 2'h1, 2, 4, st_s0},
		'{st_s0, 2'h1, 0, 0, st_s5}, '{st_s1, 2'h1, 0, 0, st_s3}};

	// ----------------------------------------
	// clock, timeout and instances
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// hang guard: the whole run needs far fewer cycles than this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			give_verdict();
		end
	end
	far_side far (.press(press), .wake_req(wake_req), .pwr_switch_n(pwr_switch_n), .rtc_alarm(rtc_alarm),
		.lan_wake(lan_wake), .usb_wake(usb_wake), .pme_n(pme_n), .pcie_wake_n(pcie_wake_n));
	power_button_wake_sequencer #(.SHORT_CYC(SC), .LONG_CYC(LC)) DUT (.clk(clk), .sys_rst(sys_rst),
		.pwr_switch_n(pwr_switch_n), .rtc_alarm(rtc_alarm), .lan_wake(lan_wake), .usb_wake(usb_wake),
		.pme_n(pme_n), .pcie_wake_n(pcie_wake_n), .os_cmd(os_cmd), .short_sleep_sel(short_sleep_sel),
		.sys_state(sys_state), .state_changed(state_changed));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// software command: one-cycle strobe, then let it settle
	task automatic os_go(input sys_state_e t);
		os_cmd = '{valid: 1'b1, target: t};
		@(negedge clk);
		os_cmd.valid = 1'b0;
		repeat (3) @(negedge clk);
	endtask : os_go
	task automatic hold_press(input int n);
		press = 1'b1;
		repeat (n) @(negedge clk);
		press = 1'b0;
		repeat (8) @(negedge clk);
	endtask : hold_press
	// level wake held a few cycles, dropped before the next os command
	task automatic wake(input int b);
		wake_req[b] = 1'b1;
		repeat (6) @(negedge clk);
		wake_req = 5'h00;
		repeat (4) @(negedge clk);
	endtask : wake
	task automatic give_verdict();
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc = 0;
		fails = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		press = 1'b0;
		wake_req = 5'h00;
		short_sleep_sel = 2'h1;
		os_cmd = '{valid: 1'b0, target: st_s0};
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		check("reset state", sys_state, st_s5);
		check("reset pulse", state_changed, 1'b0);
		// state_changed: high in the cycle the new state first shows, then low
		os_cmd = '{valid: 1'b1, target: st_s0};
		@(negedge clk);
		os_cmd.valid = 1'b0;
		check("state after cmd", sys_state, st_s0);
		check("pulse high", state_changed, 1'b1);
		@(negedge clk);
		check("pulse low", state_changed, 1'b0);
		@(negedge clk);
		check("pulse stays low", state_changed, 1'b0);
		// row loop: presses, wakes and os commands
		foreach (rows[i]) begin
			os_go(rows[i].init);
			short_sleep_sel = rows[i].sel;
			case (rows[i].act)
				0: os_go(rows[i].exp);
				1: hold_press(rows[i].arg);
				default: wake(rows[i].arg);
			endcase
			check("row state", sys_state, rows[i].exp);
		end
		// release between the two limits leaves the state alone
		os_go(st_s0);
		hold_press(50);
		check("mid release", sys_state, st_s0);
		// long press fires while still held, before release
		os_go(st_s3);
		press = 1'b1;
		repeat (LC + 6) @(negedge clk);
		check("long while held", sys_state, st_s5);
		press = 1'b0;
		repeat (8) @(negedge clk);
		check("long after release", sys_state, st_s5);
		// wake ignored in the working state
		os_go(st_s0);
		wake(`WAKE_RTC);
		check("wake in s0", sys_state, st_s0);
		// usb wake and a deep-sleep command in one cycle: the wake wins
		os_go(st_s3);
		wake_req[`WAKE_USB] = 1'b1;
		repeat (2) @(negedge clk);
		os_cmd = '{valid: 1'b1, target: st_s4};
		@(negedge clk);
		os_cmd.valid = 1'b0;
		wake_req = 5'h00;
		repeat (4) @(negedge clk);
		check("wake over cmd", sys_state, st_s0);
		// mid-run reset returns to soft-off with no change pulse
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		check("mid reset state", sys_state, st_s5);
		@(negedge clk);
		check("mid reset pulse", state_changed, 1'b0);
		give_verdict();
	end
endmodule : tb_top
